// *** rtl/amc_pkg.sv ***
// Package with constants and state types of the ADC mode and tamper control block.
package amc_pkg;
  localparam int NUM_CH = 7;
  localparam int SAMPLE_W = 24;
  localparam int CLK_NS = 25;
  localparam int CLK_HZ = 40000000;
  localparam int CS_MIN_NS = 10000;
  localparam int CS_CYCLES = (CS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_MIN_NS = 6000;
  localparam int HOLD_CYCLES = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TDM_RATE_SPS = 7227;
  localparam int TDM_TICK_CYCLES = CLK_HZ / TDM_RATE_SPS;
  localparam int SOFT_RESET_REG_CYCLES = 32;
  localparam int THRESH_SHIFT = 11;
  localparam logic [7:0] FAST_DECIM = 8'h40;
  localparam int FAST_SETS = 2;
  localparam logic [7:0] SOFT_RESET_REG_CMD = 8'hD6;
  localparam logic [7:0] LOCK_KEY = 8'h5A;
  localparam logic [2:0] TGT_CONFIG = 3'h0;
  localparam logic [2:0] TGT_LOCK = 3'h1;
  localparam logic [2:0] TGT_SOFT_RESET = 3'h2;
  localparam logic [2:0] TGT_TAMPER_CLEAR = 3'h3;
  localparam logic [2:0] TGT_DSP_RAM = 3'h4;
  localparam logic [1:0] MODE_CONV = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_WATCH = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h3;
  typedef enum logic [2:0] {ST_HOLD, ST_SOFT_RESET_REG, ST_START, ST_CONV, ST_STANDBY, ST_WATCH} amc_state_e;
endpackage : amc_pkg

// *** rtl/amc_mode_ctrl.sv ***
// Mode, reset and tamper-watch controller of a multi-channel sigma-delta ADC.
`timescale 1ns/100ps
`default_nettype none
module amc_mode_ctrl #(
  parameter int TDM_TICK_CYCLES = amc_pkg::TDM_TICK_CYCLES
) (
  input wire logic i_clk, // 40 MHz clock.
  input wire logic i_rst_b, // Power-on reset, active low.
  input wire logic i_reset_pin_n, // Reset pin, active low.
  input wire logic i_low_power_idle_n, // Standby pin, low requests standby.
  input wire logic i_cs_n, // SPI chip-select pin.
  input wire logic i_clk_ok, // Clock or crystal present.
  input wire logic i_wr_valid, // Decoded SPI write pulse.
  input wire logic [2:0] i_wr_target, // Write target class.
  input wire logic [7:0] i_wr_data, // Write data.
  input wire logic [7:0] i_wr_old, // Current content at write address.
  input wire logic i_cfg_flag_clr, // Clear for config-changed flag.
  input wire logic i_reset_done_clr, // Clear for reset-done flag.
  input wire logic i_conv_done, // New sample set pulse.
  input wire logic [amc_pkg::NUM_CH*amc_pkg::SAMPLE_W-1:0] i_chan_data, // Channel samples.
  input wire logic [amc_pkg::NUM_CH-1:0] i_channel_powerdown_reg, // Channel off bits.
  input wire logic [7:0] i_watch_cycle_length, // Samples per cycle minus one.
  input wire logic [11:0] i_watch_threshold, // Shared threshold.
  input wire logic [7:0] i_watch_required, // Required hit count.
  input wire logic i_watch_all_channels, // One for AND, zero for OR.
  input wire logic i_watch_notify_enable, // Tamper drives ready pin.
  input wire logic i_dsp_filter_en, // A DSP filter is enabled.
  input wire logic i_datapath_lock, // Datapath lock bit.
  output logic o_sample_ready_n, // Ready pin, active low.
  output logic [1:0] o_mode, // Current mode.
  output logic o_spi_enable, // SPI port open.
  output logic o_wr_done, // Write accepted pulse.
  output logic o_wr_fail, // Write refused pulse.
  output logic o_lock_active, // Lock key in place.
  output logic o_config_changed_flag, // Config-changed flag.
  output logic o_reset_done, // Reset-done flag.
  output logic o_tamper_flag, // Sticky tamper flag.
  output logic o_wave_zero, // Waveform bytes read as zero.
  output logic o_fast_filter, // Fast filter selected.
  output logic [7:0] o_fast_decim, // Fast filter decimation.
  output logic o_internal_clk, // Internal sample clock in use.
  output logic o_watch_tick, // Internal sample strobe.
  output logic o_regs_default, // Load register defaults pulse.
  output logic o_standby_exit, // Standby group defaults pulse.
  output logic o_dsp_ram_overwrite, // DSP RAM overwritten pulse.
  output logic o_dsp_ram_restore // DSP RAM default reload pulse.
);

  localparam int NCH = amc_pkg::NUM_CH;
  localparam int SW = amc_pkg::SAMPLE_W;

  // Reset release and pin synchronisers.
  logic rst_meta_r;
  logic rst_n;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic rstpin_s;
  logic stby_s;
  logic cs_s;
  logic clkok_s;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Pins cross two flops before any logic reads them.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 4'h6;
      pin_sync_r <= 4'h6;
    end else begin
      pin_meta_r <= {i_clk_ok, i_cs_n, i_low_power_idle_n, i_reset_pin_n};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign rstpin_s = pin_sync_r[0];
  assign stby_s = pin_sync_r[1];
  assign cs_s = pin_sync_r[2];
  assign clkok_s = pin_sync_r[3];

  amc_pkg::amc_state_e state_r, state_nxt;
  logic lock_r, lock_nxt;
  logic cfg_chg_r, cfg_chg_nxt;
  logic rst_done_r, rst_done_nxt;
  logic tamper_r, tamper_nxt;
  logic ready_n_r, ready_n_nxt;
  logic wave_zero_r, wave_zero_nxt;
  logic [1:0] sets_r, sets_nxt;
  logic [5:0] soft_reset_reg_cnt_r, soft_reset_reg_cnt_nxt;
  logic [8:0] cs_cnt_r, cs_cnt_nxt;
  logic cs_armed_r, cs_armed_nxt;
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic [7:0] samp_r, samp_nxt;
  logic end_r, end_nxt;
  logic det_r, det_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic dsp_pend_r, dsp_pend_nxt;
  logic dplock_q_r, dplock_q_nxt;
  logic wr_ok_r, wr_ok_nxt;
  logic wr_fail_r, wr_fail_nxt;
  logic dflt_r, dflt_nxt;
  logic sexit_r, sexit_nxt;
  logic ovr_r, ovr_nxt;
  logic restore_r, restore_nxt;
  logic tick_r, tick_nxt;
  logic cyc_start;
  logic tick;
  logic hit;
  logic [NCH-1:0] ch_flag;
  logic [NCH-1:0] ch_active;

  // Per-channel hit counters over one tamper-watch cycle.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [SW-1:0] smp;
      logic [SW:0] mag;
      logic [SW:0] lim;
      logic [7:0] cnt_r, cnt_nxt;
      always_comb begin
        smp = i_chan_data[g*SW +: SW];
        mag = smp[SW-1] ? ((SW+1)'(0) - {smp[SW-1], smp}) : {1'b0, smp};
        lim = (SW+1)'({i_watch_threshold, 11'h000});
        cnt_nxt = cnt_r;
        if (cyc_start) begin
          cnt_nxt = 8'h00;
        end else if (tick && ch_active[g] && (mag > lim) && (cnt_r != 8'hFF)) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r <= 8'h00;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
      assign ch_active[g] = ~i_channel_powerdown_reg[g];
      assign ch_flag[g] = ch_active[g] && (cnt_r >= i_watch_required);
    end
  endgenerate

  // Channel flags combine by AND or OR; no active channel never detects.
  assign hit = (|ch_active) && (i_watch_all_channels ? &(ch_flag | ~ch_active) : |ch_flag);

  // Mode sequencing, write checking, flags and ready pin.
  always_comb begin
    state_nxt = state_r;
    lock_nxt = lock_r;
    cfg_chg_nxt = cfg_chg_r;
    rst_done_nxt = rst_done_r;
    tamper_nxt = tamper_r;
    ready_n_nxt = ready_n_r;
    wave_zero_nxt = wave_zero_r;
    sets_nxt = sets_r;
    soft_reset_reg_cnt_nxt = soft_reset_reg_cnt_r;
    cs_cnt_nxt = cs_cnt_r;
    cs_armed_nxt = cs_armed_r;
    tick_cnt_nxt = tick_cnt_r;
    samp_nxt = samp_r;
    end_nxt = 1'b0;
    det_nxt = det_r;
    hold_nxt = (hold_r != 8'h00) ? hold_r - 8'h01 : 8'h00;
    dsp_pend_nxt = dsp_pend_r;
    dplock_q_nxt = i_datapath_lock;
    wr_ok_nxt = 1'b0;
    wr_fail_nxt = 1'b0;
    dflt_nxt = 1'b0;
    sexit_nxt = 1'b0;
    ovr_nxt = 1'b0;
    restore_nxt = 1'b0;
    tick_nxt = 1'b0;
    cyc_start = 1'b0;
    tick = 1'b0;
    if (dsp_pend_r && i_dsp_filter_en && (dplock_q_r != i_datapath_lock)) begin
      restore_nxt = 1'b1;
      dsp_pend_nxt = 1'b0;
    end
    if (i_cfg_flag_clr) begin
      cfg_chg_nxt = 1'b0;
    end
    if (i_reset_done_clr) begin
      rst_done_nxt = 1'b0;
    end
    if (cs_s) begin
      cs_cnt_nxt = 9'h000;
      cs_armed_nxt = 1'b1;
    end else if (cs_cnt_r != 9'(amc_pkg::CS_CYCLES)) begin
      cs_cnt_nxt = cs_cnt_r + 9'h001;
    end
    // Writes only land in conversion mode; soft reset refuses all of them.
    if (i_wr_valid) begin
      if (state_r != amc_pkg::ST_CONV) begin
        wr_fail_nxt = 1'b1;
      end else if (i_wr_target == amc_pkg::TGT_LOCK) begin
        wr_ok_nxt = 1'b1;
        lock_nxt = (i_wr_data == amc_pkg::LOCK_KEY);
      end else if (i_wr_target == amc_pkg::TGT_CONFIG) begin
        if (lock_r) begin
          wr_fail_nxt = 1'b1;
        end else begin
          wr_ok_nxt = 1'b1;
          ovr_nxt = 1'b1;
          if (i_wr_data != i_wr_old) begin
            cfg_chg_nxt = 1'b1;
          end
        end
      end else if (i_wr_target == amc_pkg::TGT_SOFT_RESET) begin
        if (lock_r) begin
          wr_fail_nxt = 1'b1;
        end else begin
          wr_ok_nxt = 1'b1;
          if (i_wr_data == amc_pkg::SOFT_RESET_REG_CMD) begin
            state_nxt = amc_pkg::ST_SOFT_RESET_REG;
            soft_reset_reg_cnt_nxt = 6'h00;
            dflt_nxt = 1'b1;
          end
        end
      end else if (i_wr_target == amc_pkg::TGT_TAMPER_CLEAR) begin
        wr_ok_nxt = 1'b1;
        if (i_wr_data[0]) begin
          tamper_nxt = 1'b0;
        end
      end else if (i_wr_target == amc_pkg::TGT_DSP_RAM) begin
        wr_ok_nxt = 1'b1;
      end else begin
        wr_fail_nxt = 1'b1;
      end
    end
    case (state_r)
      amc_pkg::ST_HOLD: begin
        ready_n_nxt = 1'b0;
        if (rstpin_s) begin
          state_nxt = amc_pkg::ST_START;
          dflt_nxt = 1'b1;
        end
      end
      amc_pkg::ST_SOFT_RESET_REG: begin
        ready_n_nxt = 1'b0;
        soft_reset_reg_cnt_nxt = soft_reset_reg_cnt_r + 6'h01;
        if (soft_reset_reg_cnt_r == 6'(amc_pkg::SOFT_RESET_REG_CYCLES - 1)) begin
          state_nxt = amc_pkg::ST_START;
          rst_done_nxt = 1'b1;
          lock_nxt = 1'b0;
          cfg_chg_nxt = 1'b0;
          tamper_nxt = 1'b0;
          dsp_pend_nxt = 1'b1;
        end
      end
      amc_pkg::ST_START: begin
        ready_n_nxt = 1'b0;
        wave_zero_nxt = 1'b1;
        sets_nxt = 2'h0;
        // Leave only from a low ready pin, so that its rise marks entry into conversion.
        if (clkok_s && stby_s && !ready_n_r && (hold_nxt == 8'h00)) begin
          state_nxt = amc_pkg::ST_CONV;
          ready_n_nxt = 1'b1;
        end
      end
      amc_pkg::ST_CONV: begin
        ready_n_nxt = 1'b1;
        if (i_conv_done) begin
          ready_n_nxt = 1'b0;
          wave_zero_nxt = 1'b0;
          if (sets_r != 2'(amc_pkg::FAST_SETS)) begin
            sets_nxt = sets_r + 2'h1;
          end
        end
        if (!stby_s) begin
          state_nxt = amc_pkg::ST_STANDBY;
        end
      end
      amc_pkg::ST_STANDBY: begin
        ready_n_nxt = 1'b1;
        if (stby_s) begin
          state_nxt = amc_pkg::ST_START;
          sexit_nxt = 1'b1;
        end else if (cs_armed_r && (cs_cnt_r == 9'(amc_pkg::CS_CYCLES))) begin
          state_nxt = amc_pkg::ST_WATCH;
          cs_armed_nxt = 1'b0;
          cyc_start = 1'b1;
        end
      end
      amc_pkg::ST_WATCH: begin
        tick_cnt_nxt = tick_cnt_r + 16'h0001;
        if (tick_cnt_r == 16'(TDM_TICK_CYCLES - 1)) begin
          tick_cnt_nxt = 16'h0000;
          tick = 1'b1;
          tick_nxt = 1'b1;
          samp_nxt = samp_r + 8'h01;
          end_nxt = (samp_r == i_watch_cycle_length);
        end
        if (hit && !det_r) begin
          tamper_nxt = 1'b1;
          det_nxt = 1'b1;
          if (i_watch_notify_enable) begin
            hold_nxt = 8'(amc_pkg::HOLD_CYCLES);
          end
        end
        ready_n_nxt = ~(det_nxt && i_watch_notify_enable);
        // The cycle ends a cycle after its last sample so that a last hit still counts.
        if (end_r) begin
          det_nxt = 1'b0;
          if (!cs_s && !stby_s) begin
            cyc_start = 1'b1;
            cs_armed_nxt = 1'b0;
          end else if (stby_s) begin
            state_nxt = amc_pkg::ST_START;
            sexit_nxt = 1'b1;
          end else begin
            state_nxt = amc_pkg::ST_STANDBY;
          end
        end
      end
      default: begin
        state_nxt = amc_pkg::ST_HOLD;
      end
    endcase
    if (cyc_start) begin
      tick_cnt_nxt = 16'h0000;
      samp_nxt = 8'h00;
      det_nxt = 1'b0;
    end
    if (hold_nxt != 8'h00) begin
      ready_n_nxt = 1'b0;
    end
    // The reset pin overrides every mode and clears lock, config-changed, tamper, hold and detect state.
    if (!rstpin_s) begin
      state_nxt = amc_pkg::ST_HOLD;
      ready_n_nxt = 1'b0;
      lock_nxt = 1'b0;
      cfg_chg_nxt = 1'b0;
      tamper_nxt = 1'b0;
      hold_nxt = 8'h00;
      det_nxt = 1'b0;
      dsp_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= amc_pkg::ST_HOLD;
      lock_r <= 1'b0;
      cfg_chg_r <= 1'b0;
      rst_done_r <= 1'b0;
      tamper_r <= 1'b0;
      ready_n_r <= 1'b0;
      wave_zero_r <= 1'b1;
      sets_r <= 2'h0;
      soft_reset_reg_cnt_r <= 6'h00;
      cs_cnt_r <= 9'h000;
      cs_armed_r <= 1'b0;
      tick_cnt_r <= 16'h0000;
      samp_r <= 8'h00;
      end_r <= 1'b0;
      det_r <= 1'b0;
      hold_r <= 8'h00;
      dsp_pend_r <= 1'b1;
      dplock_q_r <= 1'b0;
      wr_ok_r <= 1'b0;
      wr_fail_r <= 1'b0;
      dflt_r <= 1'b0;
      sexit_r <= 1'b0;
      ovr_r <= 1'b0;
      restore_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lock_r <= lock_nxt;
      cfg_chg_r <= cfg_chg_nxt;
      rst_done_r <= rst_done_nxt;
      tamper_r <= tamper_nxt;
      ready_n_r <= ready_n_nxt;
      wave_zero_r <= wave_zero_nxt;
      sets_r <= sets_nxt;
      soft_reset_reg_cnt_r <= soft_reset_reg_cnt_nxt;
      cs_cnt_r <= cs_cnt_nxt;
      cs_armed_r <= cs_armed_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      samp_r <= samp_nxt;
      end_r <= end_nxt;
      det_r <= det_nxt;
      hold_r <= hold_nxt;
      dsp_pend_r <= dsp_pend_nxt;
      dplock_q_r <= dplock_q_nxt;
      wr_ok_r <= wr_ok_nxt;
      wr_fail_r <= wr_fail_nxt;
      dflt_r <= dflt_nxt;
      sexit_r <= sexit_nxt;
      ovr_r <= ovr_nxt;
      restore_r <= restore_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Outputs come from registers, from the registered state or, for o_fast_decim, from a package constant.
  always_comb begin
    if (state_r == amc_pkg::ST_CONV) begin
      o_mode = amc_pkg::MODE_CONV;
    end else if (state_r == amc_pkg::ST_STANDBY) begin
      o_mode = amc_pkg::MODE_STANDBY;
    end else if (state_r == amc_pkg::ST_WATCH) begin
      o_mode = amc_pkg::MODE_WATCH;
    end else begin
      o_mode = amc_pkg::MODE_RESET;
    end
  end

  assign o_sample_ready_n = ready_n_r;
  assign o_spi_enable = (state_r == amc_pkg::ST_CONV);
  assign o_wr_done = wr_ok_r;
  assign o_wr_fail = wr_fail_r;
  assign o_lock_active = lock_r;
  assign o_config_changed_flag = cfg_chg_r;
  assign o_reset_done = rst_done_r;
  assign o_tamper_flag = tamper_r;
  assign o_wave_zero = wave_zero_r;
  assign o_fast_filter = (sets_r != 2'(amc_pkg::FAST_SETS));
  assign o_fast_decim = amc_pkg::FAST_DECIM;
  assign o_internal_clk = (state_r == amc_pkg::ST_WATCH);
  assign o_watch_tick = tick_r;
  assign o_regs_default = dflt_r;
  assign o_standby_exit = sexit_r;
  assign o_dsp_ram_overwrite = ovr_r;
  assign o_dsp_ram_restore = restore_r;

endmodule : amc_mode_ctrl
`default_nettype wire

// *** bench/amc_host_model.sv ***
// Host model driving the standby, chip-select and reset pins of the ADC.
`timescale 1ns/100ps
`default_nettype none
module amc_host_model (
  input wire logic i_clk, // Host clock.
  input wire logic i_go_standby, // Ask for standby.
  input wire logic i_go_watch, // Ask for a tamper watch.
  input wire logic i_go_reset, // Ask for a hardware reset.
  output logic o_low_power_idle_n, // Standby pin.
  output logic o_cs_n, // Chip-select pin.
  output logic o_reset_pin_n // Reset pin.
);
  int cs_cnt;
  // Pins start idle: no reset, no standby, no select.
  initial begin
    o_low_power_idle_n = 1'b1;
    o_cs_n = 1'b1;
    o_reset_pin_n = 1'b1;
    cs_cnt = 0;
  end
  // Pins move just after the edge; a select is never cut shorter than the minimum hold.
  always @(posedge i_clk) begin
    o_reset_pin_n <= !i_go_reset;
    o_low_power_idle_n <= !i_go_standby;
    if (o_cs_n) begin
      o_cs_n <= !(i_go_watch && i_go_standby);
      cs_cnt <= 0;
    end else if (cs_cnt < amc_pkg::CS_CYCLES + 8) begin
      cs_cnt <= cs_cnt + 1;
    end else begin
      o_cs_n <= !i_go_watch;
    end
  end
endmodule : amc_host_model
`default_nettype wire

// *** bench/amc_mode_ctrl_chk.sv ***
// Assertions on the ports of the ADC mode and tamper control block.
`timescale 1ns/100ps
`default_nettype none
module amc_mode_ctrl_chk #(
  parameter int TDM_TICK_CYCLES = amc_pkg::TDM_TICK_CYCLES
) (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_b, // Reset, active low.
  input wire logic i_wr_valid, // Write pulse.
  input wire logic [2:0] i_wr_target, // Write target.
  input wire logic [7:0] i_wr_data, // Write data.
  input wire logic i_conv_done, // New sample set.
  input wire logic i_watch_notify_enable, // Tamper notify.
  input wire logic o_sample_ready_n, // Ready pin.
  input wire logic [1:0] o_mode, // Mode.
  input wire logic o_spi_enable, // SPI open.
  input wire logic o_wr_done, // Write accepted.
  input wire logic o_wr_fail, // Write refused.
  input wire logic o_lock_active, // Lock in place.
  input wire logic o_reset_done, // Reset done.
  input wire logic o_tamper_flag, // Tamper flag.
  input wire logic o_wave_zero, // Zero waveform.
  input wire logic [7:0] o_fast_decim, // Fast decimation.
  input wire logic o_internal_clk, // Internal clock.
  input wire logic o_regs_default // Defaults pulse.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // An accepted soft reset request and the run that must follow it.
  sequence s_soft_reset_reg_req;
    i_wr_valid && i_wr_target == amc_pkg::TGT_SOFT_RESET && i_wr_data == amc_pkg::SOFT_RESET_REG_CMD && !o_lock_active
      && o_mode == amc_pkg::MODE_CONV;
  endsequence
  sequence s_soft_reset_reg_run;
    (o_regs_default && o_mode == amc_pkg::MODE_RESET) ##1 (o_mode == amc_pkg::MODE_RESET)[*8] ##[20:30] o_reset_done;
  endsequence
  a_soft_reset_reg_run: assert property (s_soft_reset_reg_req |=> s_soft_reset_reg_run)
    else $error("soft reset sequence wrong");
  a_write_answer: assert property (i_wr_valid |=> o_wr_done != o_wr_fail)
    else $error("write not answered once");
  a_refuse_idle: assert property (i_wr_valid && o_mode != amc_pkg::MODE_CONV |=> o_wr_fail)
    else $error("write accepted outside conversion");
  a_lock_refuse: assert property (i_wr_valid && o_lock_active && (i_wr_target == amc_pkg::TGT_CONFIG
    || i_wr_target == amc_pkg::TGT_SOFT_RESET) |=> o_wr_fail) else $error("locked write accepted");
  a_spi_conv: assert property ($rose(o_spi_enable) |-> $rose(o_sample_ready_n))
    else $error("conversion entry not marked by ready rise");
  a_watch_clk: assert property ($rose(o_internal_clk) |-> o_mode == amc_pkg::MODE_WATCH
    && $past(o_mode) == amc_pkg::MODE_STANDBY) else $error("watch not entered from standby");
  a_conv_ready: assert property (i_conv_done && o_mode == amc_pkg::MODE_CONV |=> !o_sample_ready_n)
    else $error("ready pin not low after sample set");
  a_wave_zero: assert property ($fell(o_wave_zero) |-> $past(i_conv_done))
    else $error("zero waveform ended without sample set");
  a_tamper_hold: assert property ($fell(o_tamper_flag) |-> o_mode == amc_pkg::MODE_RESET
    || $past(i_wr_valid && i_wr_target == amc_pkg::TGT_TAMPER_CLEAR)) else $error("tamper flag lost");
  a_notify_low: assert property ($rose(o_tamper_flag) && i_watch_notify_enable
    |-> ##[0:1] (!o_sample_ready_n)[*8]) else $error("tamper notify too short");
  a_fast_decim: assert property (o_fast_decim == amc_pkg::FAST_DECIM)
    else $error("fast decimation wrong");
endmodule : amc_mode_ctrl_chk
`default_nettype wire

// *** bench/amc_mode_ctrl_test.sv ***
// Self-checking testbench of the ADC mode and tamper control block.
`timescale 1ns/100ps
`default_nettype none
module amc_mode_ctrl_test;
  localparam int TICK = 8;
  logic i_clk, i_rst_b, i_clk_ok, i_wr_valid, i_cfg_flag_clr, i_reset_done_clr, i_conv_done;
  logic i_watch_all_channels, i_watch_notify_enable, i_dsp_filter_en, i_datapath_lock;
  logic i_reset_pin_n, i_low_power_idle_n, i_cs_n, go_standby, go_watch, go_reset;
  logic [2:0] i_wr_target;
  logic [7:0] i_wr_data, i_wr_old, i_watch_cycle_length, i_watch_required, o_fast_decim;
  logic [11:0] i_watch_threshold;
  logic [amc_pkg::NUM_CH-1:0] i_channel_powerdown_reg;
  logic [amc_pkg::NUM_CH*amc_pkg::SAMPLE_W-1:0] i_chan_data;
  logic o_sample_ready_n, o_spi_enable, o_wr_done, o_wr_fail, o_lock_active, o_config_changed_flag, o_reset_done;
  logic o_tamper_flag, o_wave_zero, o_fast_filter, o_internal_clk, o_watch_tick, o_regs_default, o_standby_exit;
  logic o_dsp_ram_overwrite, o_dsp_ram_restore;
  logic [1:0] o_mode;
  int n_mismatch, checked;
  amc_mode_ctrl #(.TDM_TICK_CYCLES(TICK)) u_amc_mode_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_reset_pin_n(i_reset_pin_n), .i_low_power_idle_n(i_low_power_idle_n), .i_cs_n(i_cs_n), .i_clk_ok(i_clk_ok),
    .i_wr_valid(i_wr_valid), .i_wr_target(i_wr_target), .i_wr_data(i_wr_data), .i_wr_old(i_wr_old),
    .i_cfg_flag_clr(i_cfg_flag_clr), .i_reset_done_clr(i_reset_done_clr), .i_conv_done(i_conv_done),
    .i_chan_data(i_chan_data), .i_channel_powerdown_reg(i_channel_powerdown_reg),
    .i_watch_cycle_length(i_watch_cycle_length), .i_watch_threshold(i_watch_threshold),
    .i_watch_required(i_watch_required), .i_watch_all_channels(i_watch_all_channels),
    .i_watch_notify_enable(i_watch_notify_enable), .i_dsp_filter_en(i_dsp_filter_en),
    .i_datapath_lock(i_datapath_lock), .o_sample_ready_n(o_sample_ready_n), .o_mode(o_mode),
    .o_spi_enable(o_spi_enable), .o_wr_done(o_wr_done), .o_wr_fail(o_wr_fail), .o_lock_active(o_lock_active),
    .o_config_changed_flag(o_config_changed_flag), .o_reset_done(o_reset_done), .o_tamper_flag(o_tamper_flag),
    .o_wave_zero(o_wave_zero), .o_fast_filter(o_fast_filter), .o_fast_decim(o_fast_decim),
    .o_internal_clk(o_internal_clk), .o_watch_tick(o_watch_tick), .o_regs_default(o_regs_default),
    .o_standby_exit(o_standby_exit), .o_dsp_ram_overwrite(o_dsp_ram_overwrite),
    .o_dsp_ram_restore(o_dsp_ram_restore));
  amc_host_model u_amc_host_model (.i_clk(i_clk), .i_go_standby(go_standby), .i_go_watch(go_watch),
    .i_go_reset(go_reset), .o_low_power_idle_n(i_low_power_idle_n), .o_cs_n(i_cs_n), .o_reset_pin_n(i_reset_pin_n));
  // Clock at 40 MHz.
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Compare a seen value with the expected one.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // Output picked by number, for bounded waits.
  function automatic logic [7:0] probe(input int sel);
    case (sel)
      0: probe = {6'h00, o_mode};
      1: probe = {7'h00, o_sample_ready_n};
      2: probe = {7'h00, o_reset_done};
      3: probe = {7'h00, o_dsp_ram_restore};
      4: probe = {7'h00, o_tamper_flag};
      5: probe = {7'h00, o_standby_exit};
      7: probe = {7'h00, o_watch_tick};
      default: probe = {7'h00, o_regs_default};
    endcase
  endfunction : probe
  // Wait, a bounded number of cycles, for an output to reach a value.
  task automatic wait_for(input int sel, input logic [7:0] v, input int lim);
    int i;
    i = 0;
    while (probe(sel) !== v && i < lim) begin
      @(posedge i_clk);
      #1;
      i++;
    end
    chk(probe(sel), v);
  endtask : wait_for
  // One write; the answer stands in the cycle after it is taken.
  task automatic wr(input logic [2:0] t, input logic [7:0] d, input logic [7:0] old, input logic ok);
    @(posedge i_clk);
    i_wr_valid <= 1'b1;
    i_wr_target <= t;
    i_wr_data <= d;
    i_wr_old <= old;
    @(posedge i_clk);
    i_wr_valid <= 1'b0;
    #1;
    chk(o_wr_done, ok);
    chk(o_wr_fail, !ok);
  endtask : wr
  // Verdict and end of run.
  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    test_done();
  end
  // Main sequence of tests.
  initial begin
    {i_rst_b, i_wr_valid, i_cfg_flag_clr, i_reset_done_clr, i_conv_done, i_watch_all_channels} = 6'h00;
    {i_dsp_filter_en, i_datapath_lock, go_standby, go_watch, go_reset, i_wr_target} = 8'h00;
    {i_wr_data, i_wr_old, i_watch_cycle_length, i_watch_required, i_watch_threshold} = 44'h0;
    i_watch_notify_enable = 1'b0;
    i_clk_ok = 1'b1;
    i_channel_powerdown_reg = 7'h00;
    i_chan_data = '0;
    n_mismatch = 0;
    checked = 0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    wait_for(1, 8'h01, 40);
    chk(o_mode, amc_pkg::MODE_CONV);
    chk(o_spi_enable, 1'b1);
    chk(o_wave_zero, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_conv_done <= 1'b1;
      @(posedge i_clk);
      i_conv_done <= 1'b0;
      #1;
      chk(o_sample_ready_n, 1'b0);
      chk(o_wave_zero, 1'b0);
      chk(o_fast_filter, k == 0);
    end
    wr(amc_pkg::TGT_CONFIG, 8'h12, 8'h00, 1'b1);
    chk(o_dsp_ram_overwrite, 1'b1);
    chk(o_config_changed_flag, 1'b1);
    @(posedge i_clk);
    i_cfg_flag_clr <= 1'b1;
    @(posedge i_clk);
    i_cfg_flag_clr <= 1'b0;
    #1 chk(o_config_changed_flag, 1'b0);
    wr(amc_pkg::TGT_LOCK, amc_pkg::LOCK_KEY, 8'h00, 1'b1);
    chk(o_lock_active, 1'b1);
    wr(amc_pkg::TGT_CONFIG, 8'h34, 8'h12, 1'b0);
    wr(amc_pkg::TGT_SOFT_RESET, amc_pkg::SOFT_RESET_REG_CMD, 8'h00, 1'b0);
    wr(3'h7, 8'h00, 8'h00, 1'b0);
    wr(amc_pkg::TGT_LOCK, 8'h00, amc_pkg::LOCK_KEY, 1'b1);
    chk(o_lock_active, 1'b0);
    wr(amc_pkg::TGT_SOFT_RESET, amc_pkg::SOFT_RESET_REG_CMD, 8'h00, 1'b1);
    chk(o_regs_default, 1'b1);
    wr(amc_pkg::TGT_CONFIG, 8'h56, 8'h00, 1'b0);
    wait_for(2, 8'h01, 60);
    wait_for(1, 8'h01, 10);
    @(posedge i_clk);
    i_reset_done_clr <= 1'b1;
    @(posedge i_clk);
    i_reset_done_clr <= 1'b0;
    #1 chk(o_reset_done, 1'b0);
    @(posedge i_clk);
    i_dsp_filter_en <= 1'b1;
    @(posedge i_clk);
    i_datapath_lock <= 1'b1;
    wait_for(3, 8'h01, 8);
    @(posedge i_clk);
    i_watch_threshold <= 12'h001;
    i_watch_required <= 8'h02;
    i_watch_all_channels <= 1'b1;
    i_watch_cycle_length <= 8'h03;
    i_watch_notify_enable <= 1'b1;
    i_channel_powerdown_reg <= 7'h7E;
    i_chan_data[23:0] <= 24'hFFF7FF;
    go_standby <= 1'b1;
    wait_for(0, amc_pkg::MODE_STANDBY, 10);
    chk(o_spi_enable, 1'b0);
    wr(amc_pkg::TGT_CONFIG, 8'h78, 8'h00, 1'b0);
    go_watch <= 1'b1;
    wait_for(0, amc_pkg::MODE_WATCH, 450);
    chk(o_internal_clk, 1'b1);
    @(posedge i_clk);
    go_watch <= 1'b0;
    wait_for(7, 8'h01, 10);
    wait_for(4, 8'h01, 100);
    @(posedge i_clk);
    #1 chk(o_sample_ready_n, 1'b0);
    wait_for(0, amc_pkg::MODE_STANDBY, 600);
    chk(o_tamper_flag, 1'b1);
    @(posedge i_clk);
    go_standby <= 1'b0;
    wait_for(5, 8'h01, 10);
    wait_for(1, 8'h01, 300);
    chk(o_mode, amc_pkg::MODE_CONV);
    wr(amc_pkg::TGT_TAMPER_CLEAR, 8'h01, 8'h00, 1'b1);
    chk(o_tamper_flag, 1'b0);
    @(posedge i_clk);
    go_reset <= 1'b1;
    wait_for(0, amc_pkg::MODE_RESET, 10);
    @(posedge i_clk);
    go_reset <= 1'b0;
    wait_for(6, 8'h01, 10);
    wait_for(1, 8'h01, 20);
    chk(o_mode, amc_pkg::MODE_CONV);
    test_done();
  end
endmodule : amc_mode_ctrl_test
bind amc_mode_ctrl amc_mode_ctrl_chk #(.TDM_TICK_CYCLES(TDM_TICK_CYCLES)) u_amc_mode_ctrl_chk (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_wr_valid(i_wr_valid), .i_wr_target(i_wr_target), .i_wr_data(i_wr_data),
  .i_conv_done(i_conv_done), .i_watch_notify_enable(i_watch_notify_enable), .o_sample_ready_n(o_sample_ready_n),
  .o_mode(o_mode), .o_spi_enable(o_spi_enable), .o_wr_done(o_wr_done), .o_wr_fail(o_wr_fail),
  .o_lock_active(o_lock_active), .o_reset_done(o_reset_done), .o_tamper_flag(o_tamper_flag),
  .o_wave_zero(o_wave_zero), .o_fast_decim(o_fast_decim), .o_internal_clk(o_internal_clk),
  .o_regs_default(o_regs_default));
`default_nettype wire
